// ---- common/ips_pkg.sv ----
package ips_pkg;

    localparam int unsigned CLK_HZ              = 40_000_000;
    localparam int unsigned TRIAL_TIME_S        = 90;
    localparam int unsigned WAIT_TIME_S         = 300;
    localparam int unsigned STABILIZE_TIME_MS   = 1000;
    localparam int unsigned FLAME_LOSS_TIME_MS  = 100;
    localparam int unsigned TRIAL_CYCLES        = TRIAL_TIME_S * CLK_HZ;
    localparam longint unsigned WAIT_CYCLES_L   = longint'(WAIT_TIME_S) * CLK_HZ;
    localparam int unsigned WAIT_CYCLES         = int'(WAIT_CYCLES_L);
    localparam int unsigned STABILIZE_CYCLES    = STABILIZE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned FLAME_LOSS_CYCLES   = FLAME_LOSS_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned TIMER_W             = 34;
    localparam int unsigned FLAME_W             = 12;
    localparam logic [FLAME_W-1:0] SPARK_OFF_LEVEL = 12'h200;
    localparam logic [FLAME_W-1:0] MAIN_ON_LEVEL   = 12'h400;

    typedef enum logic [2:0] {
        IPS_IDLE,
        IPS_TRIAL,
        IPS_STABILIZE,
        IPS_RUN,
        IPS_WAIT
    } ips_state_type;

    typedef struct packed {
        logic spark;
        logic pilot_valve;
        logic main_valve;
    } ips_outputs_type;

    typedef struct packed {
        logic proven_low;
        logic proven_high;
    } ips_flame_type;

endpackage : ips_pkg

// ---- hw/ips_flame_compare.sv ----
`timescale 1ns/1ps
`default_nettype none

// Samples the flame current and compares it against both proving levels.
module ips_flame_compare #(
    parameter int unsigned FLAME_W = 12
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic [FLAME_W-1:0]    flame_level_i,
    input  wire logic [FLAME_W-1:0]    low_level_i,
    input  wire logic [FLAME_W-1:0]    high_level_i,
    output ips_pkg::ips_flame_type     flame_o
);
    import ips_pkg::*;

    logic [FLAME_W-1:0] sync1_r;
    logic [FLAME_W-1:0] sync2_r;
    logic [FLAME_W-1:0] sync3_r;

    // The flame measurement arrives from outside the clock domain.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= flame_level_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Only a word seen alike on two edges is compared, so a sample caught mid-change is ignored.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            flame_o <= '0;
        end else if (sync2_r == sync3_r) begin
            flame_o.proven_low  <= (sync2_r >= low_level_i);
            flame_o.proven_high <= (sync2_r >= high_level_i);
        end
    end

endmodule // ips_flame_compare

`default_nettype wire

// ---- hw/ips_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Down counter that reloads on start and pulses done as it steps from one to zero.
module ips_timer #(
    parameter int unsigned W = 34
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rstn_i,
    input  wire logic          start_i,
    input  wire logic          stop_i,
    input  wire logic [W-1:0]  load_i,
    output logic               done_o,
    output logic               busy_o
);
    logic [W-1:0] count_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            count_r <= '0;
            done_o  <= 1'b0;
        end else if (stop_i) begin
            count_r <= '0;
            done_o  <= 1'b0;
        end else if (start_i) begin
            count_r <= load_i;
            done_o  <= 1'b0;
        end else begin
            done_o <= (count_r == W'(1));
            if (count_r != '0) begin
                count_r <= count_r - W'(1);
            end
        end
    end

    assign busy_o = (count_r != '0);

endmodule // ips_timer

`default_nettype wire

// ---- hw/ips_sequencer.sv ----
// Contract
// - A heat request turns on spark and pilot valve together and starts the trial timer.
// - During the trial, flame at the lower level stops the spark while the pilot stays on.
// - The main valve opens only once flame reaches the higher level.
// - Flame falling below the lower level during the trial turns the spark back on.
// - The whole trial, spark re-enables included, ends by the trial time from its start.
// - The trial time defaults to 90 seconds, after which an unproven spark stops.
// - An unproven trial ends with spark and pilot valve both off.
// - A failed trial is followed by a five-minute wait with every output off.
// - Trial and wait repeat with no lockout until the pilot proves or heat is withdrawn.
// - Removing the heat request or power abandons the wait and restarts the sequence.
// - Opening the main valve is followed by a short stabilization interval before run.
// - In run, flame loss turns off both pilot and main valve.
`timescale 1ns/1ps
`default_nettype none

module ips_sequencer #(
    parameter int unsigned          FLAME_W           = ips_pkg::FLAME_W,
    parameter longint unsigned      TRIAL_CYCLES      = ips_pkg::TRIAL_CYCLES,
    parameter longint unsigned      WAIT_CYCLES       = ips_pkg::WAIT_CYCLES_L,
    parameter longint unsigned      STABILIZE_CYCLES  = ips_pkg::STABILIZE_CYCLES,
    parameter longint unsigned      FLAME_LOSS_CYCLES = ips_pkg::FLAME_LOSS_CYCLES
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  heat_request_i,
    input  wire logic [FLAME_W-1:0]    flame_level_i,
    output logic                       spark_o,
    output logic                       pilot_valve_o,
    output logic                       main_valve_o,
    output logic                       pilot_ignition_trial_o,
    output logic                       run_mode_o
);
    import ips_pkg::*;

    localparam int unsigned TW = ips_pkg::TIMER_W;

    logic          heat_s1_r;
    logic          heat_s2_r;
    ips_flame_type flame;
    ips_state_type state_r;
    ips_state_type state_nxt;
    ips_outputs_type outs_nxt;
    logic          trial_done;
    logic          wait_done;
    logic          stab_done;
    logic          loss_done;
    logic          entering_trial;
    logic          entering_wait;
    logic          entering_stab;
    logic          loss_start;
    logic          loss_run_r;
    // Cycles spent in the present state; it wraps harmlessly during long runs.
    logic [TW-1:0] state_age_r;

    // The thermostat input is asynchronous to the clock.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            heat_s1_r <= 1'b0;
            heat_s2_r <= 1'b0;
        end else begin
            heat_s1_r <= heat_request_i;
            heat_s2_r <= heat_s1_r;
        end
    end

    ips_flame_compare #(
        .FLAME_W (FLAME_W)
    ) u_flame (
        .ref_clk_i     (ref_clk_i),
        .rstn_i        (rstn_i),
        .flame_level_i (flame_level_i),
        .low_level_i   (SPARK_OFF_LEVEL),
        .high_level_i  (MAIN_ON_LEVEL),
        .flame_o       (flame)
    );

    assign entering_trial = (state_nxt == IPS_TRIAL) && (state_r != IPS_TRIAL);
    assign entering_wait  = (state_nxt == IPS_WAIT) && (state_r != IPS_WAIT);
    assign entering_stab  = (state_nxt == IPS_STABILIZE) && (state_r != IPS_STABILIZE);
    assign loss_start     = (state_r == IPS_RUN) && !flame.proven_low && !loss_run_r;

    // The trial timer starts with the trial and is never restarted by spark re-enables.
    ips_timer #(.W(TW)) u_trial_timer (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .start_i   (entering_trial),
        .stop_i    (state_r != IPS_TRIAL && !entering_trial),
        .load_i    (TW'(TRIAL_CYCLES - 1)),
        .done_o    (trial_done),
        .busy_o    ()
    );

    ips_timer #(.W(TW)) u_wait_timer (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .start_i   (entering_wait),
        .stop_i    (state_r != IPS_WAIT && !entering_wait),
        .load_i    (TW'(WAIT_CYCLES - 1)),
        .done_o    (wait_done),
        .busy_o    ()
    );

    ips_timer #(.W(TW)) u_stab_timer (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .start_i   (entering_stab),
        .stop_i    (state_r != IPS_STABILIZE && !entering_stab),
        .load_i    (TW'(STABILIZE_CYCLES - 1)),
        .done_o    (stab_done),
        .busy_o    ()
    );

    // Flame loss in run is filtered briefly so a single noisy sample does not trip.
    ips_timer #(.W(TW)) u_loss_timer (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .start_i   (loss_start),
        .stop_i    (state_r != IPS_RUN || flame.proven_low),
        .load_i    (TW'(FLAME_LOSS_CYCLES)),
        .done_o    (loss_done),
        .busy_o    ()
    );

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            loss_run_r <= 1'b0;
        end else if (state_r != IPS_RUN || flame.proven_low) begin
            loss_run_r <= 1'b0;
        end else begin
            loss_run_r <= 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        if (!heat_s2_r) begin
            state_nxt = IPS_IDLE;
        end else begin
            unique case (state_r)
                IPS_IDLE: begin
                    state_nxt = IPS_TRIAL;
                end
                IPS_TRIAL: begin
                    if (flame.proven_high) begin
                        state_nxt = IPS_STABILIZE;
                    end else if (trial_done) begin
                        state_nxt = IPS_WAIT;
                    end
                end
                IPS_STABILIZE: begin
                    if (!flame.proven_low) begin
                        state_nxt = IPS_IDLE;
                    end else if (stab_done) begin
                        state_nxt = IPS_RUN;
                    end
                end
                IPS_RUN: begin
                    if (loss_done) begin
                        state_nxt = IPS_IDLE;
                    end
                end
                IPS_WAIT: begin
                    if (wait_done) begin
                        state_nxt = IPS_TRIAL;
                    end
                end
                default: begin
                    state_nxt = IPS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_r <= IPS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_age_r <= '0;
        end else if (state_nxt != state_r) begin
            state_age_r <= '0;
        end else begin
            state_age_r <= state_age_r + TW'(1);
        end
    end

    always_comb begin
        outs_nxt = '0;
        unique case (state_nxt)
            IPS_TRIAL: begin
                outs_nxt.pilot_valve = 1'b1;
                outs_nxt.spark = !flame.proven_low;
            end
            IPS_STABILIZE, IPS_RUN: begin
                outs_nxt.pilot_valve = 1'b1;
                outs_nxt.main_valve  = 1'b1;
            end
            default: begin
                outs_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            spark_o                <= 1'b0;
            pilot_valve_o          <= 1'b0;
            main_valve_o           <= 1'b0;
            pilot_ignition_trial_o <= 1'b0;
            run_mode_o             <= 1'b0;
        end else begin
            spark_o                <= outs_nxt.spark;
            pilot_valve_o          <= outs_nxt.pilot_valve;
            main_valve_o           <= outs_nxt.main_valve;
            pilot_ignition_trial_o <= (state_nxt == IPS_TRIAL);
            run_mode_o             <= (state_nxt == IPS_RUN);
        end
    end

    a_spark_pilot_pair: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        spark_o |-> pilot_valve_o) else $error("spark without pilot valve");

    a_spark_off_proven: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_TRIAL && state_nxt == IPS_TRIAL && flame.proven_low) |=>
        !spark_o && pilot_valve_o)
        else $error("spark still on with proven flame");

    a_main_after_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(main_valve_o) |-> $past(flame.proven_high))
        else $error("main valve opened below high level");

    a_spark_reenable: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_TRIAL && state_nxt == IPS_TRIAL && !flame.proven_low) |=> spark_o)
        else $error("spark not re-enabled on weak flame");

    a_trial_ends_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_TRIAL && trial_done && !flame.proven_high) |=>
        !spark_o && !pilot_valve_o && !main_valve_o)
        else $error("failed trial left gas or spark on");

    a_wait_all_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_WAIT) |-> !spark_o && !pilot_valve_o && !main_valve_o)
        else $error("output active during wait");

    a_wait_to_trial: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_WAIT && wait_done && heat_s2_r) |=> pilot_ignition_trial_o)
        else $error("no retry after wait");

    a_heat_off_idle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !heat_s2_r |=> !spark_o && !pilot_valve_o && !main_valve_o && state_r == IPS_IDLE)
        else $error("outputs on without heat request");

    a_run_loss_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_RUN && loss_done) |=> !pilot_valve_o && !main_valve_o)
        else $error("valves open after flame loss");

    a_stab_before_run: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(run_mode_o) |-> $past(state_r) == IPS_STABILIZE)
        else $error("run entered without stabilization");

    a_trial_start_pair: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(pilot_ignition_trial_o) |-> pilot_valve_o && (spark_o || $past(flame.proven_low)))
        else $error("trial began without spark and pilot");

    a_trial_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_TRIAL) |-> state_age_r < TW'(TRIAL_CYCLES))
        else $error("trial ran past its time");

    a_trial_time: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_TRIAL && trial_done) |-> state_age_r == TW'(TRIAL_CYCLES - 1))
        else $error("trial ended early");

    a_wait_time: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_WAIT && wait_done) |-> state_age_r == TW'(WAIT_CYCLES - 1))
        else $error("wait length wrong");

    a_stab_time: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_STABILIZE && stab_done) |-> state_age_r == TW'(STABILIZE_CYCLES - 1))
        else $error("stabilization length wrong");

    a_idle_restart: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_IDLE && heat_s2_r) |=> state_r == IPS_TRIAL)
        else $error("heat request did not start a trial");

    a_stab_weak_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_STABILIZE && !flame.proven_low) |=> !pilot_valve_o && !main_valve_o)
        else $error("gas left on after weak flame in stabilization");

    a_run_valves_on: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == IPS_RUN) |-> pilot_valve_o && main_valve_o && !spark_o)
        else $error("run without both valves");

endmodule // ips_sequencer

`default_nettype wire

// ---- dv/ips_flame_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Pilot burner and flame rod: a flame lights only when spark and pilot gas meet,
// burns at the strength the bench sets, and dies with the gas or a zero strength.
module ips_flame_model (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rstn_i,
    input  wire logic                          pilot_valve_i,
    input  wire logic                          spark_i,
    input  wire logic [ips_pkg::FLAME_W-1:0]   strength_i,
    output logic      [ips_pkg::FLAME_W-1:0]   flame_level_o
);
    import ips_pkg::*;

    logic lit_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !pilot_valve_i || strength_i == '0) begin
            lit_r <= 1'b0;
        end else if (spark_i) begin
            lit_r <= 1'b1;
        end
    end

    // With no flame the rod carries no rectified current.
    assign flame_level_o = lit_r ? strength_i : '0;
endmodule // ips_flame_model

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ips_pkg::*;

    localparam int TRIAL = 50;
    localparam int WAITC = 80;
    localparam int STAB  = 10;
    localparam int LOSS  = 4;
    localparam int GAP   = 30;
    localparam int LIMIT = 3000;

    logic               ref_clk_i = 1'b0;
    logic               rstn_i = 1'b0;
    logic               heat = 1'b0;
    logic [FLAME_W-1:0] strength = '0;
    logic [FLAME_W-1:0] flame;
    logic               spark, pilot, main_v, trial, run;
    int                 failures = 0;
    int                 n_tests = 0;
    int                 cyc = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    ips_sequencer #(.TRIAL_CYCLES(TRIAL), .WAIT_CYCLES(WAITC), .STABILIZE_CYCLES(STAB),
                    .FLAME_LOSS_CYCLES(LOSS)) u_ips_sequencer (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .heat_request_i(heat), .flame_level_i(flame),
        .spark_o(spark), .pilot_valve_o(pilot), .main_valve_o(main_v),
        .pilot_ignition_trial_o(trial), .run_mode_o(run));

    ips_flame_model u_ips_flame_model (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pilot_valve_i(pilot), .spark_i(spark),
        .strength_i(strength), .flame_level_o(flame));

    task automatic results();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures = failures + 1;
            results();
        end
    end

    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return spark;
            1: return pilot;
            2: return main_v;
            3: return run;
            default: return !(spark || pilot || main_v);
        endcase
    endfunction

    // Waits at falling edges until the chosen output reaches v; n counts the cycles.
    task automatic wait_for(input int sel, input logic v, input int max, output int n);
        n = 0;
        while (sig(sel) !== v && n < max) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("wait target", v, sig(sel));
    endtask

    task automatic call_heat(input logic [FLAME_W-1:0] s);
        int n;
        heat = 1'b0;
        repeat (GAP) @(negedge ref_clk_i);
        strength = s;
        heat = 1'b1;
        wait_for(1, 1'b1, 6, n);
        chk("spark with pilot", 1'b1, spark);
        chk("trial flag", 1'b1, trial);
    endtask

    task automatic t_fail_retry();
        int n;
        call_heat('0);
        wait_for(1, 1'b0, TRIAL + 5, n);
        chk_rng("trial length", TRIAL - 2, TRIAL, n);
        chk("spark at trial end", 1'b0, spark);
        wait_for(1, 1'b1, WAITC + 5, n);
        chk_rng("wait length", WAITC - 2, WAITC + 2, n);
        chk("retry spark", 1'b1, spark);
        $display("test fail_retry done");
    endtask

    task automatic t_restart_wait();
        int n;
        wait_for(1, 1'b0, TRIAL + 5, n);
        repeat (5) @(negedge ref_clk_i);
        chk("outputs off in wait", 1'b1, sig(4));
        call_heat('0);
        wait_for(1, 1'b0, TRIAL + 5, n);
        rstn_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk("outputs off in reset", 1'b1, sig(4));
        rstn_i = 1'b1;
        wait_for(1, 1'b1, 6, n);
        chk("trial after power restore", 1'b1, trial);
        $display("test restart_wait done");
    endtask

    task automatic t_weak_trial();
        int n;
        call_heat(12'h300);
        repeat (10) @(negedge ref_clk_i);
        chk("spark off on weak flame", 1'b0, spark);
        strength = 12'h100;
        repeat (6) @(negedge ref_clk_i);
        chk("spark re-enabled", 1'b1, spark);
        chk("main stayed shut", 1'b0, main_v);
        strength = 12'h300;
        wait_for(1, 1'b0, TRIAL + 5, n);
        chk_rng("trial with re-enable", TRIAL - 18, TRIAL - 16, n);
        $display("test weak_trial done");
    endtask

    task automatic t_prove();
        int n;
        call_heat(12'h300);
        wait_for(0, 1'b0, 10, n);
        chk("pilot held", 1'b1, pilot);
        repeat (8) @(negedge ref_clk_i);
        chk("main below high level", 1'b0, main_v);
        strength = 12'h100;
        wait_for(0, 1'b1, 8, n);
        strength = 12'h500;
        wait_for(2, 1'b1, 10, n);
        chk("spark with main", 1'b0, spark);
        chk("run during stabilize", 1'b0, run);
        wait_for(3, 1'b1, STAB + 4, n);
        chk_rng("stabilize length", STAB - 1, STAB + 2, n);
        $display("test prove done");
    endtask

    task automatic t_loss();
        int n;
        strength = '0;
        wait_for(4, 1'b1, LOSS + 8, n);
        chk("run cleared", 1'b0, run);
        $display("test loss done");
    endtask

    task automatic t_heat_off();
        int n;
        call_heat(12'h500);
        wait_for(3, 1'b1, STAB + 12, n);
        heat = 1'b0;
        wait_for(4, 1'b1, 4, n);
        repeat (LOSS + 4) @(negedge ref_clk_i);
        chk("stays idle", 1'b1, sig(4));
        chk("trial flag idle", 1'b0, trial);
        $display("test heat_off done");
    endtask

    initial begin
        repeat (2) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        chk("idle after reset", 1'b1, sig(4));
        t_fail_retry();
        t_restart_wait();
        t_weak_trial();
        t_prove();
        t_loss();
        t_heat_off();
        results();
    end
endmodule // testbench

`default_nettype wire
